// [design/hyst_compare.sv]
// one hysteresis comparator on the temperature code
module hyst_compare
  import thermistor_pkg::*;
#(
  parameter logic [6:0] SET_CODE = 7'h00,
  parameter logic [6:0] CLR_CODE = 7'h00,
  parameter bit         RISING   = 1'b1
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // sample
  input  wire logic       valid,
  input  wire logic [6:0] code,
  // indication
  output logic            flag_r
);
  logic hit_set;
  logic hit_clr;
  assign hit_set = RISING ? (code >= SET_CODE) : (code <= SET_CODE);
  assign hit_clr = RISING ? (code <= CLR_CODE) : (code >= CLR_CODE);

  // only a fresh sample may move the flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (valid) begin
      if (hit_set) begin
        flag_r <= 1'b1;
      end else if (hit_clr) begin
        flag_r <= 1'b0;
      end
    end
  end
endmodule

// [design/thermistor_charge_qualifier.sv]
// thermistor charge qualifier: thresholds, pause, conditioner, registers
module thermistor_charge_qualifier
  import thermistor_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // converter side
  input  wire logic       adc_done,
  input  wire logic [6:0] adc_code,
  input  wire logic       ship_store,
  // charger context
  input  wire logic       charger_enable,
  input  wire logic       bat_at_or_below_3v9,
  input  wire logic       chg_irq_en,
  input  wire logic       hot_irq_en,
  // register port at sub address
  input  wire reg_req_t   req,
  output logic [7:0]      rdata_r,
  // outputs
  output logic            sample_start,
  output logic            charge_pause,
  output logic            discharge_load_r,
  output logic            undervoltage_limit_disable,
  output logic            otg_autostart_lock,
  output logic            chg_irq_r,
  output logic            hot_irq_r,
  output temp_status_t    status
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_MEASURE = 3'b010,
    ST_FROZEN  = 3'b100
  } samp_state_t;

  samp_state_t  state_r;
  samp_state_t  state_nxt;
  logic [31:0]  tick_r;
  logic [6:0]   adc_hold_r;
  logic         have_sample_r;
  logic [6:0]   temperature_code_r;
  logic         code_valid_r;
  logic         code_update_r;
  logic [7:0]   ctrl_r;
  logic         cold_warning;
  logic         warm_warning;
  logic         hot_fault;
  logic         in_range_prev_r;
  logic         hot_prev_r;
  logic         period_end;

  assign period_end = (tick_r == 32'(SAMPLE_CYCLES_P - 1));

  // sample pacing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ship_store) begin
          state_nxt = ST_FROZEN;
        end else begin
          state_nxt = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (ship_store) begin
          state_nxt = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        if (!ship_store) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // period counter; held at zero while shipping
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_r <= 32'h0000_0000;
    end else if (state_r != ST_MEASURE || period_end) begin
      tick_r <= 32'h0000_0000;
    end else begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  // the converter is kicked at period start; bias stays low duty
  assign sample_start = (state_r == ST_MEASURE) && (tick_r == 32'h0);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      adc_hold_r    <= 7'h00;
      have_sample_r <= 1'b0;
    end else if (state_r == ST_MEASURE && period_end) begin
      have_sample_r <= 1'b0;
    end else if (adc_done && state_r == ST_MEASURE) begin
      adc_hold_r    <= adc_code;
      have_sample_r <= 1'b1;
    end
  end

  // readable code changes only at the end of a period
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      temperature_code_r <= 7'h00;
      code_valid_r       <= 1'b0;
      code_update_r      <= 1'b0;
    end else begin
      code_update_r <= 1'b0;
      if (state_r == ST_MEASURE && period_end && have_sample_r) begin
        temperature_code_r <= adc_hold_r;
        code_valid_r       <= 1'b1;
        code_update_r      <= 1'b1;
      end
    end
  end

  // hysteresis comparators see only published codes
  hyst_compare #(
    .SET_CODE (COLD_SET_CODE),
    .CLR_CODE (COLD_CLR_CODE),
    .RISING   (1'b1)
  ) u_cold (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .valid    (code_update_r),
    .code     (temperature_code_r),
    .flag_r   (cold_warning)
  );

  hyst_compare #(
    .SET_CODE (WARM_SET_CODE),
    .CLR_CODE (WARM_CLR_CODE),
    .RISING   (1'b0)
  ) u_warm (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .valid    (code_update_r),
    .code     (temperature_code_r),
    .flag_r   (warm_warning)
  );

  hyst_compare #(
    .SET_CODE (HOT_SET_CODE),
    .CLR_CODE (HOT_CLR_CODE),
    .RISING   (1'b0)
  ) u_hot (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .valid    (code_update_r),
    .code     (temperature_code_r),
    .flag_r   (hot_fault)
  );

  // warm flag holds until code reaches 45, so resume follows it
  assign charge_pause = cold_warning | warm_warning;

  // control register zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_ZERO_RESET;
    end else if (req.wr && req.addr == CTRL_ZERO_ADDR) begin
      ctrl_r <= req.wdata;
    end
  end

  assign undervoltage_limit_disable = ctrl_r[UVCL_DIS_BIT];
  assign otg_autostart_lock         = ctrl_r[OTG_LOCK_BIT];

  // read data; unmapped sub addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == CTRL_ZERO_ADDR) begin
        rdata_r <= ctrl_r;
      end else if (req.addr == STATUS_ADDR) begin
        rdata_r <= {1'b0, temperature_code_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // status field and charger state
  always_comb begin
    status.temperature_code = temperature_code_r;
    status.cold_warning     = cold_warning;
    status.warm_warning     = warm_warning;
    status.hot_fault        = hot_fault;
    if (hot_fault) begin
      status.temp_status_field = TSTAT_HOT;
    end else if (warm_warning) begin
      status.temp_status_field = TSTAT_WARM;
    end else if (cold_warning) begin
      status.temp_status_field = TSTAT_COLD;
    end else begin
      status.temp_status_field = TSTAT_NORMAL;
    end
    if (!charger_enable) begin
      status.charger_state = CHG_OFF;
    end else if (hot_fault) begin
      status.charger_state = CHG_HOT_FAULT;
    end else if (charge_pause) begin
      status.charger_state = CHG_TEMP_PAUSE;
    end else begin
      status.charger_state = CHG_ACTIVE;
    end
  end

  // edge history for interrupts; starts at in-range so no boot event
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_range_prev_r <= 1'b1;
      hot_prev_r      <= 1'b0;
    end else begin
      in_range_prev_r <= ~charge_pause;
      hot_prev_r      <= hot_fault;
    end
  end

  // one-cycle requests, gated by their enables
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chg_irq_r <= 1'b0;
      hot_irq_r <= 1'b0;
    end else begin
      chg_irq_r <= chg_irq_en && (in_range_prev_r == charge_pause);
      hot_irq_r <= hot_irq_en && (hot_prev_r != hot_fault);
    end
  end

  // discharge load; deliberately blind to charger enable and input power
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      discharge_load_r <= 1'b0;
    end else if (!code_valid_r) begin
      discharge_load_r <= 1'b0;
    end else if (!hot_fault || bat_at_or_below_3v9) begin
      discharge_load_r <= 1'b0;
    end else if (ctrl_r[COND_EN_BIT] && hot_fault && !hot_prev_r) begin
      discharge_load_r <= 1'b1;
    end
  end
endmodule

// [design/thermistor_pkg.sv]
// package: thresholds, register layout, timing and carrier types
package thermistor_pkg;
  localparam logic [7:0] CTRL_ZERO_ADDR    = 8'h00;
  localparam int         UVCL_DIS_BIT      = 7;
  localparam int         COND_EN_BIT       = 6;
  localparam int         OTG_LOCK_BIT      = 5;
  localparam logic [4:0] ILIM_RESET        = 5'h00;
  localparam logic [7:0] CTRL_ZERO_RESET   = 8'h00;
  localparam logic [7:0] STATUS_ADDR       = 8'h01;
  localparam logic [6:0] COLD_SET_CODE     = 7'h66;
  localparam logic [6:0] COLD_CLR_CODE     = 7'h62;
  localparam logic [6:0] WARM_SET_CODE     = 7'h29;
  localparam logic [6:0] WARM_CLR_CODE     = 7'h2d;
  localparam logic [6:0] HOT_SET_CODE      = 7'h13;
  localparam logic [6:0] HOT_CLR_CODE      = 7'h17;
  localparam real        SAMPLE_PERIOD_S   = 2.4;
  localparam real        CLK_HZ            = 10.0e6;
  localparam int         SAMPLE_CYCLES     = int'(SAMPLE_PERIOD_S * CLK_HZ);
  localparam logic [1:0] TSTAT_NORMAL      = 2'h0;
  localparam logic [1:0] TSTAT_COLD        = 2'h1;
  localparam logic [1:0] TSTAT_WARM        = 2'h2;
  localparam logic [1:0] TSTAT_HOT         = 2'h3;
  localparam logic [2:0] CHG_OFF           = 3'h0;
  localparam logic [2:0] CHG_ACTIVE        = 3'h1;
  localparam logic [2:0] CHG_TEMP_PAUSE    = 3'h5;
  localparam logic [2:0] CHG_HOT_FAULT     = 3'h6;

  typedef struct packed {
    logic [6:0] temperature_code;
    logic [1:0] temp_status_field;
    logic [2:0] charger_state;
    logic       cold_warning;
    logic       warm_warning;
    logic       hot_fault;
  } temp_status_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// [test/host_model.sv]
// host model: single-cycle register requests
module host_model
  import thermistor_pkg::*;
(
  input  wire logic [7:0] rdata_r,
  input  wire logic       clk_sys,
  output reg_req_t        req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // released fields show inverted leftovers, never a stale value
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(negedge clk_sys);
    req = '{w, !w, a, d};
    @(negedge clk_sys);
    q = rdata_r;
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// [test/thermistor_charge_qualifier_bench.sv]
// testbench: registers, threshold sweep and conditioner load
module thermistor_charge_qualifier_bench
  import thermistor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 50;
  logic         clk_sys, rst_n, adc_done, charger_enable, bat_lo;
  logic         sample_start, charge_pause, discharge_load_r;
  logic         undervoltage_limit_disable, otg_autostart_lock;
  logic         cold, warm, hot, ld, en;
  logic         ship, chg_en, hot_en, chg_irq, hot_irq, p0, h0;
  int           chg_seen, hot_seen, chg_exp, hot_exp, last, starts;
  logic [6:0]   adc_code;
  logic [7:0]   rdata_r, q, d;
  reg_req_t     req;
  temp_status_t status;
  int           fail_count, n_tests, seed, i;
  int           codes[$] = '{60, 102, 100, 98, 41, 44, 19, 22, 23, 45,
                             127, 0};
  thermistor_charge_qualifier #(.SAMPLE_CYCLES_P(P))
    i_thermistor_charge_qualifier (.clk_sys, .rst_n, .adc_done, .adc_code,
    .ship_store(ship), .charger_enable, .bat_at_or_below_3v9(bat_lo),
    .chg_irq_en(chg_en), .hot_irq_en(hot_en), .req, .rdata_r,
    .sample_start, .charge_pause, .discharge_load_r,
    .undervoltage_limit_disable, .otg_autostart_lock,
    .chg_irq_r(chg_irq), .hot_irq_r(hot_irq), .status);
  host_model i_host_model (.rdata_r, .clk_sys, .req);
  // pulses stand one cycle, so a mid-cycle look sees each exactly once
  always @(negedge clk_sys) begin
    if (chg_irq === 1'b1) chg_seen++;
    if (hot_irq === 1'b1) hot_seen++;
  end
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait so a dead sampler cannot hang the run
  task automatic wait_start;
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (sample_start !== 1'b1 && k < 4 * P);
    check("sample start", 8'(sample_start), 8'h01);
  endtask
  task automatic sample(input logic [6:0] c);
    wait_start();
    adc_done = 1'b1;
    adc_code = c;
    charger_enable = 1'($random(seed));
    {chg_en, hot_en} = 2'($random(seed));
    @(negedge clk_sys);
    adc_done = 1'b0;
    adc_code = ~c;
    wait_start();
    repeat (3) @(negedge clk_sys);
    p0 = cold | warm;
    h0 = hot;
    if (c >= 102) cold = 1; else if (c <= 98) cold = 0;
    if (c <= 41) warm = 1; else if (c >= 45) warm = 0;
    if (c <= 19 && !hot) ld = en;
    if (c <= 19) hot = 1; else if (c >= 23) hot = 0;
    if (!hot) ld = 0;
    if ((cold | warm) != p0 && chg_en) chg_exp++;
    if (hot != h0 && hot_en) hot_exp++;
    last = c;
    i_host_model.access(1'b0, STATUS_ADDR, 8'h00, q);
    check("code", q, {1'b0, c});
    check("flags", {status.cold_warning, status.warm_warning,
      status.hot_fault, charge_pause},
      {cold, warm, hot, cold | warm});
    check("field", status.temp_status_field, hot ? TSTAT_HOT : cold ?
      TSTAT_COLD : warm ? TSTAT_WARM : TSTAT_NORMAL);
    check("state", status.charger_state, !charger_enable ? CHG_OFF :
      hot ? CHG_HOT_FAULT : (cold | warm) ? CHG_TEMP_PAUSE :
      CHG_ACTIVE);
    check("load", discharge_load_r, ld);
    check("chg irq", 8'(chg_seen), 8'(chg_exp));
    check("hot irq", 8'(hot_seen), 8'(hot_exp));
    $display("sample %0d done", c);
  endtask
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
  initial begin
    seed = 4;
    {fail_count, n_tests} = '0;
    {rst_n, adc_done, adc_code, charger_enable, bat_lo} = '0;
    {ship, chg_en, hot_en} = '0;
    {cold, warm, hot, ld, en} = '0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    i_host_model.access(1'b0, CTRL_ZERO_ADDR, 8'h00, q);
    check("ctrl reset", q, CTRL_ZERO_RESET);
    check("boot", {status.cold_warning, status.warm_warning,
      status.hot_fault, discharge_load_r}, 8'h00);
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      i_host_model.access(1'b1, CTRL_ZERO_ADDR, d, q);
      i_host_model.access(1'b0, CTRL_ZERO_ADDR, 8'h00, q);
      check("ctrl", q, d);
      check("pins", {undervoltage_limit_disable, otg_autostart_lock},
        {d[UVCL_DIS_BIT], d[OTG_LOCK_BIT]});
    end
    i_host_model.access(1'b0, 8'h07, 8'h00, q);
    check("unmapped", q, 8'h00);
    i_host_model.access(1'b1, CTRL_ZERO_ADDR, 8'h40, q);
    en = 1'b1;
    $display("register test done");
    foreach (codes[i]) sample(7'(codes[i]));
    bat_lo = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("load low bat", discharge_load_r, 1'b0);
    ld = 1'b0;
    bat_lo = 1'b0;
    // shipping: converter strobes must be ignored and no period starts
    ship = 1'b1;
    starts = 0;
    repeat (2) @(negedge clk_sys);
    adc_done = 1'b1;
    adc_code = 7'h55;
    @(negedge clk_sys);
    adc_done = 1'b0;
    repeat (2 * P) begin
      @(negedge clk_sys);
      if (sample_start !== 1'b0) starts++;
    end
    i_host_model.access(1'b0, STATUS_ADDR, 8'h00, q);
    check("frozen code", q, 8'(last));
    check("frozen starts", 8'(starts), 8'h00);
    ship = 1'b0;
    $display("ship test done");
    for (i = 0; i < 4; i++) sample(7'($random(seed)));
    // mid-run reset: indications and load must drop until a new code
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    {cold, warm, hot, ld, en} = '0;
    i_host_model.access(1'b0, CTRL_ZERO_ADDR, 8'h00, q);
    check("ctrl rearm", q, CTRL_ZERO_RESET);
    check("reboot", {status.cold_warning, status.warm_warning,
      status.hot_fault, discharge_load_r}, 8'h00);
    sample(7'h05);
    $display("reset test done");
    print_verdict();
  end
endmodule

// [test/thermistor_charge_qualifier_sva.sv]
// checker: threshold, load and interrupt relations at the ports
module tcq_checker
  import thermistor_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic         chg_irq_en,
  input wire logic         hot_irq_en,
  input wire logic         bat_at_or_below_3v9,
  input wire logic         charge_pause,
  input wire logic         discharge_load_r,
  input wire logic         chg_irq_r,
  input wire logic         hot_irq_r,
  input wire temp_status_t status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic [6:0] c = status.temperature_code;
  wire logic       h = status.hot_fault;
  pause_flags_a: assert property (charge_pause ==
    (status.cold_warning | status.warm_warning)) else $error("pause bad");
  cold_set_a: assert property ($changed(c) && c >= COLD_SET_CODE
    |=> status.cold_warning) else $error("cold not set");
  warm_clear_a: assert property ($changed(c) && c >= WARM_CLR_CODE
    |=> !status.warm_warning) else $error("warm not cleared");
  hot_set_a: assert property ($changed(c) && c <= HOT_SET_CODE
    |=> h) else $error("hot not set");
  hot_clear_a: assert property ($changed(c) && c >= HOT_CLR_CODE
    |=> !h) else $error("hot not cleared");
  load_cause_a: assert property ($rose(discharge_load_r) |-> h)
    else $error("load without hot");
  load_off_a: assert property ($fell(h) |=> !discharge_load_r)
    else $error("load kept after hot");
  low_bat_a: assert property (bat_at_or_below_3v9
    |-> ##[1:2] !discharge_load_r) else $error("load kept at low bat");
  hot_irq_a: assert property ($changed(h) && hot_irq_en
    |=> hot_irq_r) else $error("no hot irq");
  range_irq_a: assert property ($changed(charge_pause) && chg_irq_en
    |=> chg_irq_r) else $error("no range irq");
endmodule
bind thermistor_charge_qualifier tcq_checker i_tcq_checker (.clk_sys,
  .rst_n, .chg_irq_en, .hot_irq_en, .bat_at_or_below_3v9, .charge_pause,
  .discharge_load_r, .chg_irq_r, .hot_irq_r, .status);
